//--- hdl/ussu_core.sv
// universal serial shift unit: shift register, buffer, edge counter,
// selectable shift clock, output latch and two-wire clock hold.
// assumes pin inputs are asynchronous and software controls are
// single-cycle pulses or levels in the clk domain.
//
// How it works
// - one 8-bit shift register for both directions, copied to a buffer
// - msb reaches data out through a latch, changing opposite the sample
// - serial input always taken from the data input pin
// - 4-bit counter, software read/write, wraps and raises overflow flag
// - shift register and counter share one clock source, except that strobe counting with the external clock counts toggle writes
// - external clock: counter counts both rising and falling edges
// - clock from external pin, timer zero compare match or strobe
// - two-wire: flag start condition, optionally hold clock low after it
// - three-wire: data modes 0 and 1, no slave select
// - eight clocks in a ring exchange master and slave contents
// - master clock pin toggles on port bit flip or toggle write
// - mode 0: sample on rising edge, shift and update on falling
// - mode 1: sample on falling edge, shift and update on rising
// - load data and enable driver half a clock before first sample
// - data driver active only while its direction bit is output
// - sixteen counted edges from zero overflow and set the flag
// - overflow flag can wake the processor from idle
// - strobe counting with toggling and external clock selected: each toggle advances the counter
// - software clocking supports a serial rate of half the clock
// - software write in a clock event cycle wins, no shift
// - latch follows first half cycle if external, always if internal
// - on completion the shift register is copied to the buffer
`timescale 1ns/1ns
module ussu_core
  import ussu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration levels
  input wire logic [1:0] wire_mode,
  input wire logic external_clock_select,
  input wire logic clock_edge_select,
  input wire logic strobe_count_sel,
  input wire logic hold_on_start,
  input wire logic hold_on_overflow,
  input wire logic port_output_reg,
  input wire logic [1:0] port_direction_reg,
  // software strobes and timer match
  input wire logic software_strobe_bit,
  input wire logic clock_toggle_bit,
  input wire logic timer0_match,
  // shift data register access
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  output logic [7:0] shift_data_reg,
  output logic [7:0] shift_buffer_reg,
  // counter and flags
  input wire logic counter_wr,
  input wire logic [3:0] counter_wdata,
  input wire logic overflow_clr,
  input wire logic start_clr,
  output logic [3:0] edge_count,
  output logic counter_overflow_flag,
  output logic start_condition_flag,
  output logic idle_wake,
  // pins
  input wire logic serial_clock_pin_in,
  input wire logic serial_input_pin,
  output logic serial_clock_out,
  output logic serial_clock_oe_n,
  output logic data_out,
  output logic data_out_oe_n
);

  logic clk_s1, clk_s2, clk_s3;
  logic din_s1, din_s2, din_s3;
  logic [7:0] next_shift, next_buffer;
  logic [3:0] next_count;
  logic next_ovf, next_start;
  logic sampled_bit, next_sampled;
  logic out_latch, next_latch;
  logic toggle_state, next_toggle;
  logic rise, fall, sample_edge, shift_edge;
  logic shift_ev, count_ev, wrap, transparent, start_det, hold_low;

  // pin synchronisers, first stage read only by the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      din_s1 <= 1'b1;
      din_s2 <= 1'b1;
      din_s3 <= 1'b1;
    end else begin
      clk_s1 <= serial_clock_pin_in;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      din_s1 <= serial_input_pin;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
    end
  end

  // edge decode and clock source selection
  always_comb begin
    rise = clk_s2 & ~clk_s3;
    fall = ~clk_s2 & clk_s3;
    // mode 0 samples rising, mode 1 samples falling
    sample_edge = clock_edge_select ? fall : rise;
    shift_edge = clock_edge_select ? rise : fall;
    if (external_clock_select) begin
      shift_ev = shift_edge;
      count_ev = strobe_count_sel ? clock_toggle_bit
                                  : (rise | fall);
    end else begin
      shift_ev = clock_edge_select ? timer0_match
                                   : software_strobe_bit;
      count_ev = shift_ev;
    end
    wrap = count_ev & ~counter_wr & (edge_count == USSU_CNT_MAX);
    transparent = ~external_clock_select |
                  (clk_s2 == clock_edge_select);
    start_det = wire_mode[1] & clk_s2 & clk_s3 &
                ~din_s2 & din_s3;
  end

  // next values of data, counter, flags and latch
  always_comb begin
    next_shift = shift_data_reg;
    next_buffer = shift_buffer_reg;
    next_count = edge_count;
    next_sampled = sampled_bit;
    next_toggle = toggle_state ^ clock_toggle_bit;
    if (external_clock_select && sample_edge) begin
      next_sampled = din_s2;
    end
    if (data_wr) begin
      next_shift = data_wdata;
    end else if (shift_ev) begin
      next_shift = {shift_data_reg[6:0],
                    external_clock_select ? sampled_bit
                                          : din_s2};
    end
    if (counter_wr) begin
      next_count = counter_wdata;
    end else if (count_ev) begin
      next_count = edge_count + 4'h1;
    end
    if (wrap) begin
      next_buffer = next_shift;
    end
    // a set in the clear cycle wins
    next_ovf = wrap | (counter_overflow_flag & ~overflow_clr);
    next_start = start_det | (start_condition_flag & ~start_clr);
    next_latch = transparent ? next_shift[7] : out_latch;
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_data_reg <= USSU_DATA_RST;
      shift_buffer_reg <= USSU_DATA_RST;
      edge_count <= USSU_CNT_RST;
      counter_overflow_flag <= USSU_FLAG_RST;
      start_condition_flag <= USSU_FLAG_RST;
      sampled_bit <= 1'b0;
      out_latch <= 1'b0;
      toggle_state <= 1'b0;
    end else begin
      shift_data_reg <= next_shift;
      shift_buffer_reg <= next_buffer;
      edge_count <= next_count;
      counter_overflow_flag <= next_ovf;
      start_condition_flag <= next_start;
      sampled_bit <= next_sampled;
      out_latch <= next_latch;
      toggle_state <= next_toggle;
    end
  end

  // pin drivers and clock hold in two-wire mode
  always_comb begin
    hold_low = wire_mode[1] & ~clk_s2 &
               ((hold_on_start & start_condition_flag) |
                (hold_on_overflow & counter_overflow_flag));
    serial_clock_out = hold_low ? 1'b0
                                : (port_output_reg ^ toggle_state);
    serial_clock_oe_n = ~(port_direction_reg[0] | hold_low);
    data_out = out_latch;
    data_out_oe_n = ~port_direction_reg[1];
    idle_wake = counter_overflow_flag;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_write_wins_shift: assert property (
    data_wr |=> shift_data_reg == $past(data_wdata))
    else $error("written data not kept");
  a_overflow_sets_flag: assert property (
    wrap |=> counter_overflow_flag && edge_count == 4'h0)
    else $error("wrap did not set flag");
  a_set_beats_clear: assert property (
    wrap && overflow_clr |=> counter_overflow_flag)
    else $error("flag clear lost an event");
  a_buffer_on_wrap: assert property (
    wrap && !data_wr |=> shift_buffer_reg ==
      {$past(shift_data_reg[6:0]), shift_data_reg[0]} || !$past(shift_ev))
    else $error("buffer not loaded on wrap");
  a_buffer_stable: assert property (
    !wrap |=> $stable(shift_buffer_reg))
    else $error("buffer changed without completion");
  a_ext_both_edges: assert property (
    external_clock_select && !strobe_count_sel && !counter_wr &&
    (rise || fall) |=> edge_count == $past(edge_count) + 4'h1)
    else $error("edge not counted");
  a_strobe_counts: assert property (
    external_clock_select && strobe_count_sel && clock_toggle_bit &&
    !counter_wr |=> (edge_count == $past(edge_count) + 4'h1) &&
    (serial_clock_out != $past(serial_clock_out) || $past(hold_low) ||
    hold_low || $changed(port_output_reg)))
    else $error("toggle strobe did not count");
  a_mode0_shift: assert property (
    external_clock_select && !clock_edge_select && !data_wr && fall
    |=> shift_data_reg[7:1] == $past(shift_data_reg[6:0]))
    else $error("mode 0 shift missing");
  a_mode1_no_fall: assert property (
    external_clock_select && clock_edge_select && !data_wr && !rise
    |=> $stable(shift_data_reg))
    else $error("mode 1 shifted off edge");
  a_internal_latch: assert property (
    !external_clock_select ##1 !external_clock_select
    |-> data_out == shift_data_reg[7])
    else $error("latch not transparent");
  a_driver_dir: assert property (
    data_out_oe_n == !port_direction_reg[1])
    else $error("driver ignores direction");

  // counter and flag checks
  a_count_write: assert property (
    counter_wr |=> edge_count == $past(counter_wdata))
    else $error("counter write lost");
  a_count_holds: assert property (
    !counter_wr && !count_ev |=> $stable(edge_count))
    else $error("counter moved without event");
  a_internal_count: assert property (
    !external_clock_select && shift_ev && !counter_wr
    |=> edge_count == $past(edge_count) + 4'h1)
    else $error("internal clock not counted");
  a_toggle_only_count: assert property (
    external_clock_select && strobe_count_sel && !clock_toggle_bit &&
    !counter_wr |=> $stable(edge_count))
    else $error("counted without toggle strobe");
  a_flag_sticky: assert property (
    counter_overflow_flag && !overflow_clr |=> counter_overflow_flag)
    else $error("overflow flag dropped");
  a_flag_clear: assert property (
    overflow_clr && !wrap |=> !counter_overflow_flag)
    else $error("overflow flag not cleared");
  a_flag_needs_wrap: assert property (
    !wrap && !counter_overflow_flag |=> !counter_overflow_flag)
    else $error("overflow flag set without wrap");
  a_write_no_wrap: assert property (
    counter_wr && !counter_overflow_flag |=> !counter_overflow_flag)
    else $error("counter write caused overflow");
  a_buffer_write: assert property (
    wrap && data_wr |=> shift_buffer_reg == $past(data_wdata))
    else $error("buffer missed written value");
  a_wake_copy: assert property (
    idle_wake == counter_overflow_flag)
    else $error("wake does not follow flag");

  // shift, sample and latch checks
  a_strobe_shift: assert property (
    !external_clock_select && !clock_edge_select &&
    software_strobe_bit && !data_wr
    |=> shift_data_reg == {$past(shift_data_reg[6:0]), $past(din_s2)})
    else $error("strobe shift wrong");
  a_timer_shift: assert property (
    !external_clock_select && clock_edge_select && timer0_match &&
    !data_wr |=> shift_data_reg[7:1] == $past(shift_data_reg[6:0]))
    else $error("timer shift missing");
  a_mode0_sample: assert property (
    external_clock_select && !clock_edge_select && rise
    |=> sampled_bit == $past(din_s2))
    else $error("mode 0 sample missing");
  a_mode1_sample: assert property (
    external_clock_select && clock_edge_select && fall
    |=> sampled_bit == $past(din_s2))
    else $error("mode 1 sample missing");
  a_sample_holds: assert property (
    !(external_clock_select && sample_edge) |=> $stable(sampled_bit))
    else $error("sample changed off edge");
  a_mode0_no_rise: assert property (
    external_clock_select && !clock_edge_select && !data_wr && !fall
    |=> $stable(shift_data_reg))
    else $error("mode 0 shifted off edge");
  a_mode1_shift: assert property (
    external_clock_select && clock_edge_select && !data_wr && rise
    |=> shift_data_reg == {$past(shift_data_reg[6:0]),
                           $past(sampled_bit)})
    else $error("mode 1 shift missing");
  a_latch_closed: assert property (
    external_clock_select && !transparent |=> $stable(data_out))
    else $error("latch changed while closed");
  a_latch_open: assert property (
    transparent |=> data_out == shift_data_reg[7])
    else $error("open latch lost msb");

  // pin and two-wire checks
  a_toggle_flips: assert property (
    clock_toggle_bit |=> toggle_state != $past(toggle_state))
    else $error("toggle did not flip");
  a_clock_pin: assert property (
    !hold_low |-> serial_clock_out == (port_output_reg ^ toggle_state))
    else $error("clock pin level wrong");
  a_hold_low_pin: assert property (
    hold_low |-> !serial_clock_out && !serial_clock_oe_n)
    else $error("hold did not drive low");
  a_start_sets: assert property (
    start_det |=> start_condition_flag)
    else $error("start flag not set");
endmodule

//--- hdl/ussu_pkg.sv
// constants shared by the universal serial shift unit
// assumes a single 100 MHz system clock and synchronous active-low reset
package ussu_pkg;
  // widths of the data path and the edge counter
  localparam int USSU_DATA_W = 8;
  localparam int USSU_CNT_W = 4;
  // clock source selection: {external_clock_select, clock_edge_select}
  localparam logic [1:0] USSU_CS_STROBE = 2'h0;
  localparam logic [1:0] USSU_CS_TIMER = 2'h1;
  localparam logic [1:0] USSU_CS_EXT_POS = 2'h2;
  localparam logic [1:0] USSU_CS_EXT_NEG = 2'h3;
  // wire modes
  localparam logic [1:0] USSU_WM_NONE = 2'h0;
  localparam logic [1:0] USSU_WM_THREE = 2'h1;
  localparam logic [1:0] USSU_WM_TWO = 2'h2;
  localparam logic [1:0] USSU_WM_TWO_HOLD = 2'h3;
  // reset values and counter maximum
  localparam logic [7:0] USSU_DATA_RST = 8'h00;
  localparam logic [3:0] USSU_CNT_RST = 4'h0;
  localparam logic [3:0] USSU_CNT_MAX = 4'hF;
  localparam logic USSU_FLAG_RST = 1'b0;
endpackage

//--- verification/ussu_remote_master.sv
// remote three-wire master model, one byte per frame in spi mode 0
// assumes the device samples on rising clock edges and shifts on falling
`timescale 1ns/1ns
module ussu_remote_master (
  // frame control
  input wire logic go,
  input wire logic [7:0] tx,
  output logic [7:0] rx,
  output logic busy,
  // pins
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // idle: clock low, data line low
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    rx = 8'h00;
    busy = 1'b0;
  end
  // eight clock periods of 160 ns with 80 ns high, msb first, clock still between frames
  always @(posedge go) begin
    busy = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i]; // half a period before sampling
      #80 sck = 1'b1;
      rx = {rx[6:0], miso};
      #80 sck = 1'b0;
    end
    mosi = ~mosi; // line driven to the inverse of the last bit, shows no held value
    #80 busy = 1'b0;
  end
endmodule

//--- verification/universal_serial_shift_unit_test.sv
// bench for the serial shift unit: external slave transfers, software
// clocked transfer, write priority; remote master model on the pins
`timescale 1ns/1ns
module universal_serial_shift_unit_test;
  import ussu_pkg::*;
  logic clk, rst_n, ext, edge_sel, sw, tgl, tmr, go, busy, sck, mosi;
  logic data_wr, counter_wr, overflow_clr, data_out, data_out_oe_n;
  logic counter_overflow_flag, idle_wake, scs, sco;
  logic [1:0] dir;
  logic [7:0] data_wdata, mine, theirs, rx, shift_data_reg, shift_buffer_reg;
  logic [3:0] counter_wdata, edge_count;
  logic [7:0] notes[$];
  int seed = 32'hc91dce1b;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  // design and far side
  ussu_core ussu_core_i (.clk(clk), .rst_n(rst_n), .wire_mode(USSU_WM_THREE),
    .external_clock_select(ext), .clock_edge_select(edge_sel),
    .strobe_count_sel(scs), .hold_on_start(1'b0), .hold_on_overflow(1'b0),
    .port_output_reg(1'b0), .port_direction_reg(dir),
    .software_strobe_bit(sw), .clock_toggle_bit(tgl), .timer0_match(tmr),
    .data_wr(data_wr), .data_wdata(data_wdata),
    .shift_data_reg(shift_data_reg), .shift_buffer_reg(shift_buffer_reg),
    .counter_wr(counter_wr), .counter_wdata(counter_wdata),
    .overflow_clr(overflow_clr), .start_clr(1'b0), .edge_count(edge_count),
    .counter_overflow_flag(counter_overflow_flag),
    .start_condition_flag(), .idle_wake(idle_wake),
    .serial_clock_pin_in(sck), .serial_input_pin(ext ? mosi : 1'b1),
    .serial_clock_out(sco), .serial_clock_oe_n(), .data_out(data_out),
    .data_out_oe_n(data_out_oe_n));
  ussu_remote_master ussu_remote_master_i (.go(go), .tx(theirs), .rx(rx),
    .busy(busy), .sck(sck), .mosi(mosi), .miso(data_out));
  // clock and cycle ceiling
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      results();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // write data and counter, clear the flag, all in one cycle
  task automatic wr(input logic [7:0] d, input logic [3:0] c);
    @(negedge clk);
    {data_wr, counter_wr, overflow_clr} = 3'h7;
    data_wdata = d;
    counter_wdata = c;
    @(negedge clk);
    {data_wr, counter_wr, overflow_clr} = 3'h0;
  endtask
  task results;
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // compare each completed byte with the oldest note
  always @(posedge counter_overflow_flag) begin
    #1;
    if (notes.size() == 0) num_errors++;
    else chk(shift_buffer_reg, notes.pop_front());
    chk({7'h00, idle_wake}, 8'h01);
  end
  // main sequence
  initial begin
    {clk, rst_n, ext, edge_sel, sw, tgl, tmr, go} = 8'h00;
    {scs, dir} = 3'h3;
    {data_wr, counter_wr, overflow_clr, data_wdata, counter_wdata} = 0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk(shift_data_reg, 8'h00);
    chk({edge_count, 3'h0, counter_overflow_flag}, 8'h00);
    chk({7'h00, data_out_oe_n}, 8'h00);
    // write in a strobe cycle wins, msb reaches the pin
    @(negedge clk);
    {data_wr, sw} = 2'h3;
    data_wdata = 8'hA5;
    @(negedge clk);
    {data_wr, sw} = 2'h0;
    @(negedge clk);
    chk(shift_data_reg, 8'hA5);
    chk({7'h00, data_out}, 8'h01);
    wr(8'h00, 4'h9);
    chk({4'h0, edge_count}, 8'h09);
    // software clocked byte: strobe and timer match take turns
    wr(8'h00, 4'h0);
    notes.push_back(8'hFF);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      {edge_sel, tmr, sw, tgl} = {i[0], i[0], ~i[0], 1'b1};
      @(negedge clk);
      {tmr, sw, tgl} = 3'h0;
    end
    repeat (3) @(negedge clk);
    chk({4'h0, edge_count}, 8'h00);
    // toggle strobes count while the external clock is selected
    {ext, edge_sel, scs} = 3'h5;
    wr(8'h00, 4'h0);
    repeat (3) begin
      @(negedge clk);
      tgl = 1'b1;
      @(negedge clk);
      tgl = 1'b0;
    end
    @(negedge clk);
    chk({4'h0, edge_count}, 8'h03);
    chk({7'h00, sco}, 8'h01);
    // data driver follows its direction bit
    {scs, dir} = 3'h1;
    @(negedge clk);
    chk({7'h00, data_out_oe_n}, 8'h01);
    dir = 2'h3;
    // external clock mode 0 slave bytes against the remote master
    {ext, edge_sel} = 2'h2;
    repeat (2) begin
      mine = $random(seed);
      theirs = $random(seed);
      wr(mine, 4'h0);
      notes.push_back(theirs);
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      repeat (400) if (busy) @(negedge clk);
      repeat (5) @(negedge clk);
      chk(rx, mine);
      chk(shift_data_reg, theirs);
      chk({4'h0, edge_count}, 8'h00);
    end
    chk(notes.size(), 8'h00);
    results();
  end
endmodule
